// *** verilog/dtm_pkg.sv ***
// dtm_pkg: constants and carrier types of the dual timer block
// assumes one system clock; pins arrive unsynchronised
package dtm_pkg;

    // ************************************************************
    // special function register addresses
    // ************************************************************
    localparam logic [7:0] ADDR_TIMER_CONTROL      = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE         = 8'h89;
    localparam logic [7:0] ADDR_TIMER_A_COUNT_LOW  = 8'h8a;
    localparam logic [7:0] ADDR_TIMER_B_COUNT_LOW  = 8'h8b;
    localparam logic [7:0] ADDR_TIMER_A_COUNT_HIGH = 8'h8c;
    localparam logic [7:0] ADDR_TIMER_B_COUNT_HIGH = 8'h8d;
    localparam logic [7:0] REG_RESET               = 8'h00;

    // ************************************************************
    // timer_control bit positions
    // ************************************************************
    localparam int TIMER_CONTROL_TB_OVF  = 7;
    localparam int TIMER_CONTROL_TB_RUN  = 6;
    localparam int TIMER_CONTROL_TA_OVF  = 5;
    localparam int TIMER_CONTROL_TA_RUN  = 4;
    localparam int TIMER_CONTROL_EB_FLAG = 3;
    localparam int TIMER_CONTROL_EB_TYPE = 2;
    localparam int TIMER_CONTROL_EA_FLAG = 1;
    localparam int TIMER_CONTROL_EA_TYPE = 0;

    // ************************************************************
    // timer_mode bit positions and mode codes
    // ************************************************************
    localparam int TIMER_MODE_TB_GATE = 7;
    localparam int TIMER_MODE_TB_SRC  = 6;
    localparam int TIMER_MODE_TB_MHI  = 5;
    localparam int TIMER_MODE_TB_MLO  = 4;
    localparam int TIMER_MODE_TA_GATE = 3;
    localparam int TIMER_MODE_TA_SRC  = 2;
    localparam int TIMER_MODE_TA_MHI  = 1;
    localparam int TIMER_MODE_TA_MLO  = 0;

    localparam logic [1:0] MODE_13BIT  = 2'h0;
    localparam logic [1:0] MODE_16BIT  = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT  = 2'h3;

    // ************************************************************
    // prescaler
    // ************************************************************
    localparam logic [1:0] PRE_DIV12 = 2'h0;
    localparam logic [1:0] PRE_DIV4  = 2'h1;
    localparam logic [1:0] PRE_DIV48 = 2'h2;
    localparam logic [5:0] DIV_12    = 6'h0c;
    localparam logic [5:0] DIV_4     = 6'h04;
    localparam logic [5:0] DIV_48    = 6'h30;
    localparam logic [2:0] EXT_DIV_LAST = 3'h7;

    // ************************************************************
    // synchronised pins
    // ************************************************************
    localparam int PIN_N      = 5;
    localparam int PIN_IRQ_A  = 0;
    localparam int PIN_IRQ_B  = 1;
    localparam int PIN_CNT_A  = 2;
    localparam int PIN_CNT_B  = 3;
    localparam int PIN_EXTCLK = 4;

    typedef struct packed {
        logic       ovf;
        logic [7:0] hi;
        logic [7:0] lo;
    } dtm_step_s;

    typedef struct packed {
        logic [7:0]       timer_control;
        logic [7:0]       timer_mode;
        logic [7:0]       timer_a_count_low;
        logic [7:0]       timer_b_count_low;
        logic [7:0]       timer_a_count_high;
        logic [7:0]       timer_b_count_high;
        logic [5:0]       pre_cnt;
        logic [2:0]       ext_cnt;
        logic [PIN_N-1:0] sync1;
        logic [PIN_N-1:0] sync2;
        logic [PIN_N-1:0] sync3;
        logic [PIN_N-1:0] filt;
        logic [PIN_N-1:0] filt_d;
        logic [7:0]       rdata;
    } dtm_state_s;

    localparam dtm_state_s STATE_RESET = '0;

endpackage

// *** verilog/dtm_timer.sv ***
// dtm_timer: timer A/B control, mode, count and external interrupt flags
// assumes a cpu special function register port and one-cycle vector acks
// Summary of operation
// - timer B overflow sets control bit 7
// - timer B flag cleared by write or ack
// - timer A overflow sets control bit 5
// - timer A flag cleared by write or ack
// - run bit 6 enables timer B, gated
// - run bit 4 enables timer A, gated
// - ext B flag set on edge/level, cleared
// - ext A flag set on edge/level, cleared
// - type bit 2: 0 level, 1 edge
// - type bit 0: 0 level, 1 edge
// - input B sense from polarity select
// - gate B requires input B active
// - gate A requires input A active
// - source B: prescaled clock or pin falls
// - source A: prescaled clock or pin falls
// - B modes: 13, 16, reload, inactive
// - A modes: 13, 16, reload, split
// - timer A low byte read/write
// - timer B low byte read/write
// - timer A high byte read/write
// - 13-bit: high byte plus five low bits
// - 8-bit reload from unchanged high byte
// - split high byte uses B run, flag
// - prescaler: /12, /4, /48, ext/8
`timescale 1ns/1ps
`default_nettype none
module dtm_timer
    import dtm_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    input  wire logic       ext_irq_a_input,
    input  wire logic       ext_irq_b_input,
    input  wire logic       timer_a_count_pin,
    input  wire logic       timer_b_count_pin,
    input  wire logic       ext_clk_pin,
    input  wire logic       ext_irq_a_polarity,
    input  wire logic       ext_irq_b_polarity,
    input  wire logic [1:0] prescale_select,
    input  wire logic       timer_a_sysclk_select,
    input  wire logic       timer_b_sysclk_select,
    input  wire logic       ack_timer_a,
    input  wire logic       ack_timer_b,
    input  wire logic       ack_ext_a,
    input  wire logic       ack_ext_b,
    output logic            timer_a_overflow_flag,
    output logic            timer_b_overflow_flag,
    output logic            ext_irq_a_flag,
    output logic            ext_irq_b_flag
);

    // ************************************************************
    // state: one registered struct and its next value
    // ************************************************************

    dtm_state_s st;
    dtm_state_s next_st;

    // ************************************************************
    // one count step of a timer in the given mode
    // ************************************************************
    function automatic dtm_step_s tmr_step(
        input logic [1:0] mode,
        input logic [7:0] hi,
        input logic [7:0] lo,
        input logic       en
    );
        logic [8:0] l9;
        logic [5:0] l5;
        logic [8:0] h9;
        tmr_step = '{ovf: 1'b0, hi: hi, lo: lo};
        l9 = {1'b0, lo} + 9'h001;
        l5 = {1'b0, lo[4:0]} + 6'h01;
        h9 = {1'b0, hi} + 9'h001;
        if (en) begin
            case (mode)
                MODE_13BIT: begin
                    // carry out of bit 4 steps the high byte
                    tmr_step.lo = {lo[7:5], l5[4:0]};
                    if (l5[5]) begin
                        tmr_step.hi  = h9[7:0];
                        tmr_step.ovf = h9[8];
                    end
                end
                MODE_16BIT: begin
                    tmr_step.lo = l9[7:0];
                    if (l9[8]) begin
                        tmr_step.hi  = h9[7:0];
                        tmr_step.ovf = h9[8];
                    end
                end
                MODE_RELOAD: begin
                    // high byte keeps the reload value
                    tmr_step.lo  = l9[8] ? hi : l9[7:0];
                    tmr_step.ovf = l9[8];
                end
                default: begin
                    // split halves count as plain bytes
                    tmr_step.lo  = l9[7:0];
                    tmr_step.ovf = l9[8];
                end
            endcase
        end
    endfunction

    // ************************************************************
    // working signals
    // ************************************************************

    logic [PIN_N-1:0] pins;
    logic [PIN_N-1:0] fall;
    logic [PIN_N-1:0] rise;
    logic [5:0]       div;
    logic             pre_tick;
    logic             ext_tick;
    logic             tick_a;
    logic             tick_b;
    logic             act_a;
    logic             act_b;
    logic             edge_a;
    logic             edge_b;
    logic             split;
    logic             en_a;
    logic             en_ah;
    logic             en_b;
    logic             ovf_b;
    dtm_step_s        ra;
    dtm_step_s        rh;
    dtm_step_s        rb;
    logic [7:0]       tc;
    logic [7:0]       tm;

    assign pins = {ext_clk_pin, timer_b_count_pin, timer_a_count_pin,
                   ext_irq_b_input, ext_irq_a_input};

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_st = st;
        tc      = st.timer_control;
        tm      = st.timer_mode;

        // ************************************************************
        // three-stage pin sync, change taken once stages 2 and 3 agree
        // ************************************************************
        for (int i = 0; i < PIN_N; i++) begin
            next_st.sync1[i]  = pins[i];
            next_st.sync2[i]  = st.sync1[i];
            next_st.sync3[i]  = st.sync2[i];
            if (st.sync2[i] == st.sync3[i]) begin
                next_st.filt[i] = st.sync3[i];
            end
            next_st.filt_d[i] = st.filt[i];
        end
        fall = st.filt_d & ~st.filt;
        rise = ~st.filt_d & st.filt;

        // ************************************************************
        // prescaler
        // ************************************************************
        case (prescale_select)
            PRE_DIV12: div = DIV_12;
            PRE_DIV4:  div = DIV_4;
            PRE_DIV48: div = DIV_48;
            default:   div = DIV_48;
        endcase
        ext_tick = rise[PIN_EXTCLK] && (st.ext_cnt == EXT_DIV_LAST);
        if (rise[PIN_EXTCLK]) begin
            next_st.ext_cnt = st.ext_cnt + 3'h1;
        end
        pre_tick = (st.pre_cnt >= div - 6'h01);
        next_st.pre_cnt = pre_tick ? 6'h00 : st.pre_cnt + 6'h01;
        // code 11: external clock over eight
        if (prescale_select == MODE_SPLIT) begin
            pre_tick = ext_tick;
        end
        tick_a = timer_a_sysclk_select | pre_tick;
        tick_b = timer_b_sysclk_select | pre_tick;

        // ************************************************************
        // external input sense and edges
        // ************************************************************
        act_a  = ext_irq_a_polarity ? st.filt[PIN_IRQ_A] : ~st.filt[PIN_IRQ_A];
        act_b  = ext_irq_b_polarity ? st.filt[PIN_IRQ_B] : ~st.filt[PIN_IRQ_B];
        edge_a = ext_irq_a_polarity ? rise[PIN_IRQ_A] : fall[PIN_IRQ_A];
        edge_b = ext_irq_b_polarity ? rise[PIN_IRQ_B] : fall[PIN_IRQ_B];

        // ************************************************************
        // timer A
        // ************************************************************
        split = (tm[TIMER_MODE_TA_MHI:TIMER_MODE_TA_MLO] == MODE_SPLIT);
        en_a  = tc[TIMER_CONTROL_TA_RUN]
              & (~tm[TIMER_MODE_TA_GATE] | act_a)
              & (tm[TIMER_MODE_TA_SRC] ? fall[PIN_CNT_A] : tick_a);
        ra    = tmr_step(tm[TIMER_MODE_TA_MHI:TIMER_MODE_TA_MLO], st.timer_a_count_high,
                         st.timer_a_count_low, en_a);
        en_ah = split & tc[TIMER_CONTROL_TB_RUN] & tick_a;
        rh    = tmr_step(MODE_SPLIT, 8'h00, st.timer_a_count_high, en_ah);
        next_st.timer_a_count_low  = ra.lo;
        next_st.timer_a_count_high = split ? rh.lo : ra.hi;

        // ************************************************************
        // timer B: run by mode only while A is split, no pin counting
        // ************************************************************
        if (split) begin
            en_b = tick_b;
        end else begin
            en_b = tc[TIMER_CONTROL_TB_RUN]
                 & (~tm[TIMER_MODE_TB_GATE] | act_b)
                 & (tm[TIMER_MODE_TB_SRC] ? fall[PIN_CNT_B] : tick_b);
        end
        en_b = en_b & (tm[TIMER_MODE_TB_MHI:TIMER_MODE_TB_MLO] != MODE_SPLIT);
        rb   = tmr_step(tm[TIMER_MODE_TB_MHI:TIMER_MODE_TB_MLO], st.timer_b_count_high,
                        st.timer_b_count_low, en_b);
        next_st.timer_b_count_low  = rb.lo;
        next_st.timer_b_count_high = rb.hi;
        ovf_b = split ? rh.ovf : rb.ovf;

        // ************************************************************
        // flags: software write, then ack clear, then hardware set wins
        // ************************************************************
        if (sfr_wr && sfr_addr == ADDR_TIMER_CONTROL) begin
            tc = sfr_wdata;
        end
        if (ack_timer_a) begin
            tc[TIMER_CONTROL_TA_OVF] = 1'b0;
        end
        if (ack_timer_b) begin
            tc[TIMER_CONTROL_TB_OVF] = 1'b0;
        end
        if (ack_ext_a && tc[TIMER_CONTROL_EA_TYPE]) begin
            tc[TIMER_CONTROL_EA_FLAG] = 1'b0;
        end
        if (ack_ext_b && tc[TIMER_CONTROL_EB_TYPE]) begin
            tc[TIMER_CONTROL_EB_FLAG] = 1'b0;
        end
        tc[TIMER_CONTROL_TA_OVF]  = tc[TIMER_CONTROL_TA_OVF] | ra.ovf;
        tc[TIMER_CONTROL_TB_OVF]  = tc[TIMER_CONTROL_TB_OVF] | ovf_b;
        tc[TIMER_CONTROL_EA_FLAG] = tc[TIMER_CONTROL_EA_FLAG]
                         | (tc[TIMER_CONTROL_EA_TYPE] ? edge_a : act_a);
        tc[TIMER_CONTROL_EB_FLAG] = tc[TIMER_CONTROL_EB_FLAG]
                         | (tc[TIMER_CONTROL_EB_TYPE] ? edge_b : act_b);
        next_st.timer_control = tc;

        // ************************************************************
        // register writes take priority over counting
        // ************************************************************
        if (sfr_wr) begin
            case (sfr_addr)
                ADDR_TIMER_MODE:         next_st.timer_mode = sfr_wdata;
                ADDR_TIMER_A_COUNT_LOW:  next_st.timer_a_count_low = sfr_wdata;
                ADDR_TIMER_B_COUNT_LOW:  next_st.timer_b_count_low = sfr_wdata;
                ADDR_TIMER_A_COUNT_HIGH: next_st.timer_a_count_high = sfr_wdata;
                ADDR_TIMER_B_COUNT_HIGH: next_st.timer_b_count_high = sfr_wdata;
                default:                 next_st.timer_mode = tm;
            endcase
        end

        // ************************************************************
        // read data, registered; unmapped reads as zero
        // ************************************************************
        if (sfr_rd) begin
            case (sfr_addr)
                ADDR_TIMER_CONTROL:      next_st.rdata = st.timer_control;
                ADDR_TIMER_MODE:         next_st.rdata = st.timer_mode;
                ADDR_TIMER_A_COUNT_LOW:  next_st.rdata = st.timer_a_count_low;
                ADDR_TIMER_B_COUNT_LOW:  next_st.rdata = st.timer_b_count_low;
                ADDR_TIMER_A_COUNT_HIGH: next_st.rdata = st.timer_a_count_high;
                ADDR_TIMER_B_COUNT_HIGH: next_st.rdata = st.timer_b_count_high;
                default:                 next_st.rdata = REG_RESET;
            endcase
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs, straight from the state register
    // ************************************************************

    assign sfr_rdata             = st.rdata;
    assign timer_a_overflow_flag = st.timer_control[TIMER_CONTROL_TA_OVF];
    assign timer_b_overflow_flag = st.timer_control[TIMER_CONTROL_TB_OVF];
    assign ext_irq_a_flag        = st.timer_control[TIMER_CONTROL_EA_FLAG];
    assign ext_irq_b_flag        = st.timer_control[TIMER_CONTROL_EB_FLAG];

endmodule
`default_nettype wire

// *** test/dtm_timer_props.sv ***
// dtm_timer_props: port assertions for dtm_timer
// assumes bench stops a timer before acknowledging its flag
`timescale 1ns/1ps
`default_nettype none
module dtm_timer_props
    import dtm_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic       ack_timer_a,
    input wire logic       ack_timer_b,
    input wire logic       timer_a_overflow_flag,
    input wire logic       timer_b_overflow_flag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic ctl_wr;
    assign ctl_wr = sfr_wr && sfr_addr == ADDR_TIMER_CONTROL;
    sequence mode_wr_s; sfr_wr && sfr_addr == ADDR_TIMER_MODE; endsequence
    sequence mode_rd_s; sfr_rd && sfr_addr == ADDR_TIMER_MODE; endsequence
    chk_mode_readback: assert property (mode_wr_s ##2 mode_rd_s |=> sfr_rdata == $past(sfr_wdata, 3))
        else $error("mode readback wrong");
    chk_rd_unmapped: assert property (sfr_rd && (sfr_addr < 8'h88 || sfr_addr > 8'h8d) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rd_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved");
    chk_ctl_flags: assert property (sfr_rd && sfr_addr == ADDR_TIMER_CONTROL |=> sfr_rdata[7] == $past(timer_b_overflow_flag) && sfr_rdata[5] == $past(timer_a_overflow_flag))
        else $error("control read disagrees with flags");
    chk_ack_ta_clear: assert property (ack_timer_a && !ctl_wr |=> !timer_a_overflow_flag)
        else $error("timer a ack did not clear");
    chk_ack_tb_clear: assert property (ack_timer_b && !ctl_wr |=> !timer_b_overflow_flag)
        else $error("timer b ack did not clear");
    chk_ta_flag_hold: assert property (timer_a_overflow_flag && !ack_timer_a && !ctl_wr |=> timer_a_overflow_flag)
        else $error("timer a flag dropped");
    chk_tb_flag_hold: assert property (timer_b_overflow_flag && !ack_timer_b && !ctl_wr |=> timer_b_overflow_flag)
        else $error("timer b flag dropped");
    chk_reset_clear: assert property ($fell(rst) |-> !timer_a_overflow_flag && !timer_b_overflow_flag && sfr_rdata == 8'h00)
        else $error("outputs not clear after reset");
endmodule
bind dtm_timer dtm_timer_props u_props (.core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .ack_timer_a(ack_timer_a), .ack_timer_b(ack_timer_b),
    .timer_a_overflow_flag(timer_a_overflow_flag), .timer_b_overflow_flag(timer_b_overflow_flag));
`default_nettype wire

// *** test/dtm_cpu_model.sv ***
// dtm_cpu_model: vectoring side, one ack cycle for all requested sources together
// assumes requests arrive on the falling edge
`timescale 1ns/1ps
`default_nettype none
module dtm_cpu_model (
    input  wire logic       core_clk,
    input  wire logic [3:0] vec_req,
    input  wire logic [1:0] lat,
    output logic      [3:0] ack
);
    logic [3:0] pend = 4'h0;
    logic [3:0] req_q = 4'h0;
    // request sampled on the rising edge, away from the bench's drive edge
    always @(posedge core_clk) req_q <= vec_req;
    logic [1:0] wait_cnt = 2'h0;
    initial ack = 4'h0;
    // latency of lat cycles, then a single-cycle pulse
    always @(negedge core_clk) begin
        ack <= 4'h0;
        if (req_q != 4'h0) begin
            pend <= req_q;
            wait_cnt <= lat;
        end else if (pend != 4'h0 && wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end else if (pend != 4'h0) begin
            ack <= pend;
            pend <= 4'h0;
        end
    end
endmodule
`default_nettype wire

// *** test/dtm_timer_tb.sv ***
// dtm_timer_tb: register, overflow, gate and interrupt flag tests
// assumes dtm_cpu_model for vector acknowledges
`timescale 1ns/1ps
`default_nettype none
module dtm_timer_tb
    import dtm_pkg::*;
;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, seen;
    logic       wr = 1'b0, rd = 1'b0;
    logic [4:0] pin = 5'h00;
    logic [1:0] pol = 2'h3, pre = 2'h0, ssel = 2'h3, lat = 2'h0;
    logic [3:0] vreq = 4'h0, ack, fl;
    logic [7:0] regs [6] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8e};
    int         n_mismatch = 0, n_tests = 0, cyc = 0;
    always #10 core_clk = ~core_clk;
    dtm_timer dut (.core_clk(core_clk), .rst(rst), .sfr_addr(addr), .sfr_wr(wr),
        .sfr_wdata(wdata), .sfr_rd(rd), .sfr_rdata(rdata), .ext_irq_a_input(pin[0]),
        .ext_irq_b_input(pin[1]), .timer_a_count_pin(pin[2]), .timer_b_count_pin(pin[3]),
        .ext_clk_pin(pin[4]), .ext_irq_a_polarity(pol[0]), .ext_irq_b_polarity(pol[1]),
        .prescale_select(pre), .timer_a_sysclk_select(ssel[0]),
        .timer_b_sysclk_select(ssel[1]), .ack_timer_a(ack[0]), .ack_timer_b(ack[1]),
        .ack_ext_a(ack[2]), .ack_ext_b(ack[3]), .timer_a_overflow_flag(fl[0]),
        .timer_b_overflow_flag(fl[1]), .ext_irq_a_flag(fl[2]), .ext_irq_b_flag(fl[3]));
    dtm_cpu_model cpu (.core_clk(core_clk), .vec_req(vreq), .lat(lat), .ack(ack));
    // ****************************************
    // access tasks
    // ****************************************
    task automatic final_report;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(negedge core_clk);
        wr = 1'b0;
        rd = 1'b0;
        seen = rdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string n);
        acc(1'b0, a, 8'h00);
        check(n, seen, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic vec(input logic [3:0] v);
        @(negedge core_clk);
        vreq = v;
        @(negedge core_clk);
        vreq = 4'h0;
        idle(6);
    endtask
    // run a timer from a preset and stop it with the given control value
    task automatic run(input logic [7:0] md, input logic [7:0] ha, input logic [7:0] la,
                       input logic [7:0] lb, input logic [7:0] go, input logic [7:0] stop);
        acc(1'b1, 8'h89, md);
        acc(1'b1, 8'h8c, ha);
        acc(1'b1, 8'h8a, la);
        acc(1'b1, 8'h8b, lb);
        acc(1'b1, 8'h88, go);
        idle(6);
        acc(1'b0, 8'h88, 8'h00);
        acc(1'b1, 8'h88, stop);
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report;
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        idle(20);
        rst = 1'b0;
        foreach (regs[i]) rchk(regs[i], 8'h00, "reset value");
        for (int i = 2; i < 5; i++) begin
            acc(1'b1, regs[i], 8'ha5);
            rchk(regs[i], 8'ha5, "count byte");
        end
        acc(1'b1, 8'h89, 8'h33);
        rchk(8'h89, 8'h33, "mode byte");
        run(8'h01, 8'hff, 8'hfd, 8'h00, 8'h10, 8'h20);
        check("a 16-bit flag", {7'h00, seen[5]}, 8'h01);
        rchk(8'h8c, 8'h00, "a 16-bit high");
        vec(4'h1);
        check("a ack", {7'h00, fl[0]}, 8'h00);
        run(8'h00, 8'hff, 8'h1d, 8'h00, 8'h10, 8'h20);
        check("a 13-bit flag", {7'h00, seen[5]}, 8'h01);
        rchk(8'h8c, 8'h00, "a 13-bit high");
        acc(1'b1, 8'h88, 8'h00);
        check("a soft clear", {7'h00, fl[0]}, 8'h00);
        run(8'h02, 8'h80, 8'hfe, 8'h00, 8'h10, 8'h00);
        check("reload flag", {7'h00, seen[5]}, 8'h01);
        rchk(8'h8c, 8'h80, "reload high");
        acc(1'b0, 8'h8a, 8'h00);
        check("reload low", seen & 8'hf0, 8'h80);
        run(8'h20, 8'h00, 8'h00, 8'hfe, 8'h40, 8'h80);
        check("b ovf flag", {7'h00, seen[7]}, 8'h01);
        rchk(8'h88, 8'h80, "b flag bit");
        lat = 2'h2;
        vec(4'h2);
        check("b ack", {7'h00, fl[1]}, 8'h00);
        run(8'h03, 8'hfe, 8'h11, 8'h00, 8'h40, 8'h80);
        check("split flag", {7'h00, seen[7]}, 8'h01);
        rchk(8'h8a, 8'h11, "split low idle");
        acc(1'b1, 8'h88, 8'h00);
        check("b soft clear", {7'h00, fl[1]}, 8'h00);
        run(8'h09, 8'h00, 8'h55, 8'h00, 8'h10, 8'h10);
        rchk(8'h8a, 8'h55, "gate closed");
        pin[0] = 1'b1;
        idle(10);
        acc(1'b0, 8'h8a, 8'h00);
        check("gate open", {7'h00, seen != 8'h55}, 8'h01);
        acc(1'b1, 8'h88, 8'h00);
        check("a level flag", {7'h00, fl[2]}, 8'h01);
        pin[0] = 1'b0;
        idle(8);
        acc(1'b1, 8'h88, 8'h01);
        check("a level clear", {7'h00, fl[2]}, 8'h00);
        pin[0] = 1'b1;
        idle(8);
        check("a edge flag", {7'h00, fl[2]}, 8'h01);
        vec(4'h4);
        check("a edge ack", {7'h00, fl[2]}, 8'h00);
        pol[1] = 1'b0;
        idle(8);
        check("b active low", {7'h00, fl[3]}, 8'h01);
        vec(4'h8);
        check("b level ack", {7'h00, fl[3]}, 8'h01);
        pin[1] = 1'b1;
        idle(8);
        acc(1'b1, 8'h88, 8'h00);
        check("b level clear", {7'h00, fl[3]}, 8'h00);
        run(8'h05, 8'h00, 8'h00, 8'h00, 8'h10, 8'h10);
        for (int i = 0; i < 3; i++) begin
            pin[2] = 1'b1;
            idle(6);
            pin[2] = 1'b0;
            idle(6);
        end
        rchk(8'h8a, 8'h03, "pin count");
        final_report;
    end
endmodule
`default_nettype wire
